// ---- frm_pkg.sv ----
// Constants shared by the frequency and revolution meter
`default_nettype none
package frm_pkg;
    localparam int NCH = 4;
    localparam int VAL_W = 16;
    localparam int EDGE_W = 20;
    localparam int PER_W = 30;
    localparam int DIV_W = 48;
    localparam int STEP_W = 6;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_DATA0 = 8'h04;
    localparam logic [7:0] A_CFG0 = 8'h20;
    localparam logic [7:0] A_DIV0 = 8'h30;
    localparam logic [7:0] A_LO0 = 8'h40;
    localparam logic [7:0] A_HI0 = 8'h50;
    localparam logic [7:0] A_ISTAT = 8'h60;
    localparam logic [7:0] A_IMASK = 8'h64;
    // ========================================
    // Fields
    localparam int CFG_FAST = 0;
    localparam int CFG_REV = 1;
    localparam int CFG_FALL = 2;
    localparam int CFG_INV = 3;
    localparam int CFG_GATE = 4;
    localparam logic [2:0] GATE_PERIOD = 3'h7;
    localparam int ST_HI = 4;
    localparam int ST_ERR = 15;
    localparam int IRQ_LIM = 4;
    localparam int IRQ_ERR = 5;
    localparam int IRQ_W = 6;
    localparam logic [7:0] CFG_RST = 8'h40;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [15:0] LO_RST = 16'h0000;
    localparam logic [15:0] HI_RST = 16'hffff;
    // ========================================
    // Timing
    localparam longint CLK_HZ = 100_000_000;
    localparam real GATE_BASE_MS = 62.5;
    localparam int GATE_BASE_CYC = int'(GATE_BASE_MS * 1.0e-3 * CLK_HZ);
    localparam longint BASE_PER_S = 16;
    localparam longint RPM_PER_HZ = 60;
    localparam int LOW_MAX_HZ = 1000;
    localparam int HIGH_MAX_HZ = 50000;
    // Half of the shortest period in each range
    localparam int GAP_LOW_CYC = int'(CLK_HZ / (2 * LOW_MAX_HZ));
    localparam int GAP_HIGH_CYC = int'(CLK_HZ / (2 * HIGH_MAX_HZ));
    // Gate select 0..6 = 62.5,125,250,500,1000,2000,8000 ms
    function automatic logic [7:0] gate_mult(input logic [2:0] sel);
        case (sel)
            3'h6:    gate_mult = 8'h80;
            3'h7:    gate_mult = 8'h01;
            default: gate_mult = 8'h01 << sel;
        endcase
    endfunction
endpackage
`default_nettype wire

// ---- frm_meter.sv ----
// Four channel frequency and revolution meter with Wishbone registers
// Function
// - Each channel selects 1 kHz or 50 kHz range
// - Only channel one may use 50 kHz
// - Revolution mode reports rev/min instead of Hz
// - Count rising edge, or falling when selected
// - Inversion negates both limit outputs
// - Selectable gate time, count then convert
// - Value refreshed once per measurement window
// - Slow option measures time between edges
// - Count divided by pulses per revolution
// - Factor defaults to one, zero means one
// - Below lower limit sets bits 0-3
// - Above upper limit sets bits 4-7
// - Limits never disturb the measurement
// - Limit outputs follow threshold crossings
// - Status word then four data words
// - Group error on counter overflow
//
// Our own choices: the placing of the registers and register access over Wishbone.
`default_nettype none
// ========================================
// Per channel input front end
module frm_chan
    import frm_pkg::*;
#(
    parameter int GATE_CYC = GATE_BASE_CYC,
    parameter int GAP_LOW = GAP_LOW_CYC,
    parameter int GAP_HIGH = GAP_HIGH_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              pin,
    input  wire logic              fast,
    input  wire logic              falling,
    input  wire logic [2:0]        gate_sel,
    input  wire logic              base_tick,
    output logic                   done,
    output logic [EDGE_W-1:0]      edges,
    output logic [PER_W-1:0]       period,
    output logic                   ovf
);
    logic              s1_q, s2_q, s3_q;
    logic [16:0]       gap_q;
    logic [7:0]        tick_q;
    logic [EDGE_W-1:0] cnt_q;
    logic [PER_W-1:0]  per_q;
    logic              cnt_ovf_q;
    logic              raw, hit, pmode, win_end;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign raw = falling ? (s3_q & ~s2_q) : (s2_q & ~s3_q);
    // Edges closer than half the range's shortest period are glitches
    assign hit = raw && gap_q >= (fast ? 17'(GAP_HIGH) : 17'(GAP_LOW));
    assign pmode = gate_sel == GATE_PERIOD;
    assign win_end = base_tick && tick_q == gate_mult(gate_sel) - 8'h01;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_q <= '1;
        end else if (hit) begin
            gap_q <= '0;
        end else if (gap_q != '1) begin
            gap_q <= gap_q + 17'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_q <= '0;
            cnt_q <= '0;
            cnt_ovf_q <= 1'b0;
            per_q <= '0;
            done <= 1'b0;
            edges <= '0;
            period <= '1;
            ovf <= 1'b0;
        end else begin
            done <= 1'b0;
            if (pmode) begin
                tick_q <= '0;
                per_q <= (hit || per_q == '1) ? '0 : per_q + 30'h1;
                if (hit || per_q == '1) begin
                    done <= 1'b1;
                    period <= per_q;
                    ovf <= 1'b0;
                end
            end else begin
                if (base_tick) begin
                    tick_q <= win_end ? 8'h00 : tick_q + 8'h01;
                end
                if (win_end) begin
                    done <= 1'b1;
                    edges <= cnt_q;
                    ovf <= cnt_ovf_q;
                    cnt_q <= EDGE_W'(hit);
                    cnt_ovf_q <= 1'b0;
                end else if (hit) begin
                    if (cnt_q == '1) begin
                        cnt_ovf_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 20'h1;
                    end
                end
            end
        end
    end
endmodule

// ========================================
// Top: channels, shared divider, registers
module frm_meter
    import frm_pkg::*;
#(
    parameter int GATE_CYC = GATE_BASE_CYC,
    parameter int GAP_LOW = GAP_LOW_CYC,
    parameter int GAP_HIGH = GAP_HIGH_CYC
) (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output logic [31:0]         wb_dat_o,
    output logic                wb_ack_o,
    input  wire logic [NCH-1:0] pulse_in,
    output logic [NCH-1:0]      limit_lo_o,
    output logic [NCH-1:0]      limit_hi_o,
    output logic                irq_o
);
    typedef enum logic [1:0] {FRM_IDLE, FRM_DIV, FRM_STORE} frm_state_t;

    frm_state_t              st_q;
    logic [7:0]              cfg_q [NCH];
    logic [15:0]             div_q [NCH];
    logic [15:0]             lo_q [NCH];
    logic [15:0]             hi_q [NCH];
    logic [VAL_W-1:0]        data_q [NCH];
    logic [NCH-1:0]          lo_fl_q, hi_fl_q, ovf_q, pend_q, ch_fast;
    logic [NCH-1:0]          done;
    logic [EDGE_W-1:0]       edges [NCH];
    logic [PER_W-1:0]        period [NCH];
    logic [NCH-1:0]          c_ovf;
    logic [31:0]             base_q;
    logic                    base_tick;
    logic [1:0]              ch_q;
    logic [DIV_W-1:0]        num_q, den_q, rem_q;
    logic [STEP_W-1:0]       step_q;
    logic                    sovf_q;
    logic [DIV_W-1:0]        rem_sh;
    logic [DIV_W-1:0]        num_c, den_c;
    logic [15:0]             fac;
    logic [VAL_W-1:0]        val;
    logic [IRQ_W-1:0]        ist_q, imask_q, iev;
    logic [15:0]             status;
    logic                    wr, rd_req;

    // ========================================
    // Gate time base shared by all channels
    assign base_tick = base_q == 32'(GATE_CYC - 1);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            base_q <= '0;
        end else begin
            base_q <= base_tick ? 32'h0 : base_q + 32'h1;
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        assign ch_fast[i] = (i == 0) && cfg_q[i][CFG_FAST];
        frm_chan #(
            .GATE_CYC (GATE_CYC),
            .GAP_LOW  (GAP_LOW),
            .GAP_HIGH (GAP_HIGH)
        ) u_chan (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .pin       (pulse_in[i]),
            .fast      (ch_fast[i]),
            .falling   (cfg_q[i][CFG_FALL]),
            .gate_sel  (cfg_q[i][CFG_GATE +: 3]),
            .base_tick (base_tick),
            .done      (done[i]),
            .edges     (edges[i]),
            .period    (period[i]),
            .ovf       (c_ovf[i])
        );
    end

    // ========================================
    // Conversion: value = num / den, one channel at a time
    assign fac = (div_q[ch_q] == 16'h0) ? DIV_RST : div_q[ch_q];
    always_comb begin
        if (cfg_q[ch_q][CFG_GATE +: 3] == GATE_PERIOD) begin
            num_c = DIV_W'(CLK_HZ);
            // Period holds the edge spacing minus one cycle
            den_c = (DIV_W'(period[ch_q]) + DIV_W'(1)) * DIV_W'(fac);
        end else begin
            num_c = DIV_W'(edges[ch_q]) * DIV_W'(BASE_PER_S);
            den_c = DIV_W'(gate_mult(cfg_q[ch_q][CFG_GATE +: 3]))
                  * DIV_W'(fac);
        end
        if (cfg_q[ch_q][CFG_REV]) begin
            num_c = num_c * DIV_W'(RPM_PER_HZ);
        end
    end
    assign rem_sh = {rem_q[DIV_W-2:0], num_q[DIV_W-1]};
    assign val = (num_q[DIV_W-1:VAL_W] != '0) ? '1 : num_q[VAL_W-1:0];

    // Pending done flags: a new window wins over the clear of the old one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~((st_q == FRM_STORE) ? 4'(1) << ch_q
                                                      : 4'h0)) | done;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= FRM_IDLE;
            ch_q <= '0;
            num_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            step_q <= '0;
            sovf_q <= 1'b0;
        end else begin
            case (st_q)
                FRM_IDLE: begin
                    if (pend_q != '0) begin
                        st_q <= FRM_DIV;
                        ch_q <= pend_q[0] ? 2'd0 : pend_q[1] ? 2'd1
                              : pend_q[2] ? 2'd2 : 2'd3;
                    end
                    step_q <= '0;
                    rem_q <= '0;
                end
                FRM_DIV: begin
                    if (step_q == '0 && rem_q == '0 && num_q != num_c) begin
                        num_q <= num_c;
                        den_q <= den_c;
                        sovf_q <= c_ovf[ch_q];
                        step_q <= 6'h1;
                    end else if (step_q == '0) begin
                        num_q <= num_c;
                        den_q <= den_c;
                        sovf_q <= c_ovf[ch_q];
                        step_q <= 6'h1;
                    end else begin
                        // Restoring division, one quotient bit per cycle
                        rem_q <= (rem_sh >= den_q) ? rem_sh - den_q : rem_sh;
                        num_q <= {num_q[DIV_W-2:0], rem_sh >= den_q};
                        step_q <= step_q + 6'h1;
                        if (step_q == 6'(DIV_W)) begin
                            st_q <= FRM_STORE;
                        end
                    end
                end
                FRM_STORE: st_q <= FRM_IDLE;
                default:   st_q <= FRM_IDLE;
            endcase
        end
    end

    // ========================================
    // Data words and limit flags updated together in the store state after conversion
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_q <= '{default: '0};
            lo_fl_q <= '0;
            hi_fl_q <= '0;
            ovf_q <= '0;
        end else if (st_q == FRM_STORE) begin
            data_q[ch_q] <= val;
            // Flags are derived from the result only; counting goes on
            lo_fl_q[ch_q] <= val < lo_q[ch_q];
            hi_fl_q[ch_q] <= val > hi_q[ch_q];
            ovf_q[ch_q] <= sovf_q || num_q[DIV_W-1:VAL_W] != '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            limit_lo_o <= '0;
            limit_hi_o <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                limit_lo_o[i] <= lo_fl_q[i] ^ cfg_q[i][CFG_INV];
                limit_hi_o[i] <= hi_fl_q[i] ^ cfg_q[i][CFG_INV];
            end
        end
    end

    assign status = {|ovf_q, 7'h0, hi_fl_q, lo_fl_q};

    // ========================================
    // Interrupts: sticky, write one to clear, set wins
    assign iev = {(st_q == FRM_STORE) && (sovf_q || val == '1),
                  (st_q == FRM_STORE) && (val < lo_q[ch_q] || val > hi_q[ch_q]),
                  done};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ist_q <= '0;
            imask_q <= '0;
            irq_o <= 1'b0;
        end else begin
            ist_q <= (ist_q & ~((wr && wb_adr_i == A_ISTAT && wb_sel_i[0])
                      ? wb_dat_i[IRQ_W-1:0] : 6'h0)) | iev;
            if (wr && wb_adr_i == A_IMASK && wb_sel_i[0]) begin
                imask_q <= wb_dat_i[IRQ_W-1:0];
            end
            irq_o <= |(ist_q & imask_q);
        end
    end

    // ========================================
    // Wishbone slave: one wait state, unmapped reads return zero
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = rd_req && wb_we_i;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= rd_req;
            wb_dat_o <= '0;
            if (wb_adr_i == A_STATUS) begin
                wb_dat_o <= 32'(status);
            end
            for (int i = 0; i < NCH; i++) begin
                if (wb_adr_i == A_DATA0 + 8'(4 * i)) wb_dat_o <= 32'(data_q[i]);
                if (wb_adr_i == A_CFG0 + 8'(4 * i)) wb_dat_o <= 32'(cfg_q[i]);
                if (wb_adr_i == A_DIV0 + 8'(4 * i)) wb_dat_o <= 32'(div_q[i]);
                if (wb_adr_i == A_LO0 + 8'(4 * i)) wb_dat_o <= 32'(lo_q[i]);
                if (wb_adr_i == A_HI0 + 8'(4 * i)) wb_dat_o <= 32'(hi_q[i]);
            end
            if (wb_adr_i == A_ISTAT) wb_dat_o <= 32'(ist_q);
            if (wb_adr_i == A_IMASK) wb_dat_o <= 32'(imask_q);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q <= '{default: CFG_RST};
            div_q <= '{default: DIV_RST};
            lo_q <= '{default: LO_RST};
            hi_q <= '{default: HI_RST};
        end else if (wr) begin
            for (int i = 0; i < NCH; i++) begin
                if (wb_adr_i == A_CFG0 + 8'(4 * i) && wb_sel_i[0])
                    cfg_q[i] <= wb_dat_i[7:0];
                if (wb_adr_i == A_DIV0 + 8'(4 * i) && wb_sel_i[0])
                    div_q[i][7:0] <= wb_dat_i[7:0];
                if (wb_adr_i == A_DIV0 + 8'(4 * i) && wb_sel_i[1])
                    div_q[i][15:8] <= wb_dat_i[15:8];
                if (wb_adr_i == A_LO0 + 8'(4 * i) && wb_sel_i[0])
                    lo_q[i][7:0] <= wb_dat_i[7:0];
                if (wb_adr_i == A_LO0 + 8'(4 * i) && wb_sel_i[1])
                    lo_q[i][15:8] <= wb_dat_i[15:8];
                if (wb_adr_i == A_HI0 + 8'(4 * i) && wb_sel_i[0])
                    hi_q[i][7:0] <= wb_dat_i[7:0];
                if (wb_adr_i == A_HI0 + 8'(4 * i) && wb_sel_i[1])
                    hi_q[i][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ========================================
    // Assertions
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_low_only;
        ch_fast[NCH-1:1] == '0;
    endproperty
    a_low_only: assert property (p_low_only) else $error("fast on ch>1");

    property p_inv;
        ##1 limit_lo_o[0] == ($past(lo_fl_q[0]) ^ $past(cfg_q[0][CFG_INV]));
    endproperty
    a_inv: assert property (p_inv) else $error("lo out wrong");

    property p_fac;
        st_q == FRM_DIV && div_q[ch_q] == 16'h0 |-> fac == DIV_RST;
    endproperty
    a_fac: assert property (p_fac) else $error("zero factor");

    property p_lo;
        st_q == FRM_STORE
            |=> status[ch_q] == (data_q[ch_q] < $past(lo_q[ch_q]));
    endproperty
    a_lo: assert property (p_lo) else $error("lower flag wrong");

    property p_hi;
        st_q == FRM_STORE
            |=> status[ST_HI + ch_q] == (data_q[ch_q] > $past(hi_q[ch_q]));
    endproperty
    a_hi: assert property (p_hi) else $error("upper flag wrong");

    property p_err;
        st_q == FRM_STORE && num_q[DIV_W-1:VAL_W] != '0 |=> status[ST_ERR];
    endproperty
    a_err: assert property (p_err) else $error("error flag wrong");

    property p_refresh;
        !$stable(data_q[0]) |-> $past(st_q) == FRM_STORE;
    endproperty
    a_refresh: assert property (p_refresh) else $error("stray update");

    property p_conv;
        st_q == FRM_IDLE && pend_q != '0 |-> ##[50:51] st_q == FRM_STORE;
    endproperty
    a_conv: assert property (p_conv) else $error("slow convert");

    property p_ack;
        rd_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");

    property p_irq;
        ##1 irq_o == |($past(ist_q) & $past(imask_q));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    c_store: cover property (st_q == FRM_STORE ##1 lo_fl_q != '0);
    c_rev: cover property (st_q == FRM_STORE && cfg_q[ch_q][CFG_REV]);
    c_irq: cover property (irq_o);
endmodule
`default_nettype wire

// ---- frm_pulse_src.sv ----
// Pulse source model standing in for the sensors on the four inputs
`default_nettype none
module frm_pulse_src
    import frm_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [NCH-1:0]      en,
    input  wire logic [NCH-1:0][7:0] hi_cyc,
    input  wire logic [NCH-1:0][7:0] lo_cyc,
    output logic [NCH-1:0]           pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NCH-1:0][7:0] cnt_q;
    // ========================================
    // Square wave per channel; a switched-off sensor rests low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            pulse <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!en[i]) begin
                    cnt_q[i] <= 8'h00;
                    pulse[i] <= 1'b0;
                end else if (cnt_q[i] + 8'h01
                             >= (pulse[i] ? hi_cyc[i] : lo_cyc[i])) begin
                    cnt_q[i] <= 8'h00;
                    pulse[i] <= ~pulse[i];
                end else begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- frm_meter_tb.sv ----
// Self-checking bench for the four channel frequency meter
`default_nettype none
module frm_meter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import frm_pkg::*;
    localparam int TMO = 40000;
    logic                clk_sys;
    logic                rst;
    logic                cyc;
    logic                stb;
    logic                we;
    logic [7:0]          adr;
    logic [3:0]          sel;
    logic [31:0]         dat_w;
    logic [31:0]         dat_r;
    logic                ack;
    logic [NCH-1:0]      pulse;
    logic [NCH-1:0]      lim_lo;
    logic [NCH-1:0]      lim_hi;
    logic                irq;
    logic [NCH-1:0]      en;
    logic [NCH-1:0][7:0] hi_cyc;
    logic [NCH-1:0][7:0] lo_cyc;
    logic [31:0]         q;
    logic [7:0]          cfg [NCH];
    logic [15:0]         fac [NCH];
    int                  bad_count;
    int                  samples_checked;
    integer              seed;
    int                  cycles;

    always #5 clk_sys = ~clk_sys;

    // Short gate base and edge gaps keep every window a few hundred cycles
    frm_meter #(.GATE_CYC(100), .GAP_LOW(4), .GAP_HIGH(2)) DUT (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .pulse_in(pulse),
        .limit_lo_o(lim_lo), .limit_hi_o(lim_hi), .irq_o(irq)
    );
    frm_pulse_src src (
        .clk_sys(clk_sys), .rst(rst), .en(en), .hi_cyc(hi_cyc),
        .lo_cyc(lo_cyc), .pulse(pulse)
    );

    // ========================================
    // Checking and bus helpers
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // Value for e edges in a window of m base periods
    function automatic int f(int e, int m, int fc, bit rv);
        if (fc == 0) fc = 1;
        return e * 16 * (rv ? 60 : 1) / (m * fc);
    endfunction

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1);
        r = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        // Ack comes one cycle after the request is taken
        chk("ack_lat", n, 2);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == TMO) begin
            bad_count++;
            summarize();
        end
    end

    // ========================================
    // Main sequence
    initial begin
        seed = 87781;
        clk_sys = 1'b0;
        rst = 1'b1;
        {cyc, stb, we, adr, sel, dat_w} = '0;
        en = '0;
        hi_cyc = {NCH{8'h05}};
        lo_cyc = {NCH{8'h05}};
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        wb(0, A_CFG0, 0, q); chk("cfg0_rst", q, {24'h0, CFG_RST});
        wb(0, A_DIV0, 0, q); chk("div0_rst", q, {16'h0, DIV_RST});
        wb(0, A_HI0, 0, q); chk("hi0_rst", q, {16'h0, HI_RST});
        wb(0, 8'h7c, 0, q); chk("unmapped", q, 32'h0);
        // Ch0 low range, ch1 rev, ch2 falling slow mode, ch3 inverted
        cfg = '{8'h20, 8'h22, 8'h74, 8'h28};
        for (int i = 0; i < NCH; i++) begin
            fac[i] = 16'(1 + {$random(seed)} % 4);
        end
        fac[1] = 16'h0000;
        for (int i = 0; i < NCH; i++) begin
            wb(1, A_CFG0 + 8'(4 * i), {24'h0, cfg[i]}, q);
            wb(1, A_DIV0 + 8'(4 * i), {16'h0, fac[i]}, q);
            wb(0, A_CFG0 + 8'(4 * i), 0, q);
            chk("cfg", q, {24'h0, cfg[i]});
        end
        wb(1, A_LO0, 32'hffff, q);
        wb(1, A_HI0 + 8'h04, 32'h0, q);
        en <= 4'hf;
        repeat (1500) @(posedge clk_sys);
        wb(0, A_DATA0, 0, q);
        chk("data0", 32'(q >= f(38, 4, fac[0], 0)
            && q <= f(42, 4, fac[0], 0)), 1);
        wb(0, A_DATA0 + 8'h04, 0, q);
        chk("data1", 32'(q >= f(38, 4, 0, 1)
            && q <= f(42, 4, 0, 1)), 1);
        wb(0, A_DATA0 + 8'h08, 0, q); chk("data2", q, 32'hffff);
        wb(0, A_DATA0 + 8'h0c, 0, q);
        chk("data3", 32'(q >= f(38, 4, fac[3], 0)
            && q <= f(42, 4, fac[3], 0)), 1);
        wb(0, A_STATUS, 0, q);
        chk("status", q, 32'h8021);
        chk("lim_lo", {28'h0, lim_lo}, 32'h9);
        chk("lim_hi", {28'h0, lim_hi}, 32'ha);
        wb(1, A_IMASK, 32'h1 << IRQ_LIM, q);
        repeat (3) @(posedge clk_sys);
        chk("irq_on", {31'h0, irq}, 1);
        wb(1, A_IMASK, 32'h0, q);
        repeat (3) @(posedge clk_sys);
        chk("irq_mask", {31'h0, irq}, 0);
        // Remove the violations; stale limit events must clear
        wb(1, A_LO0, 32'h0, q);
        wb(1, A_HI0 + 8'h04, 32'hffff, q);
        wb(1, A_CFG0 + 8'h08, 32'h24, q);
        repeat (1500) @(posedge clk_sys);
        wb(1, A_ISTAT, 32'h3f, q);
        wb(0, A_ISTAT, 0, q); chk("istat_w1c", {30'h0, q[5:4]}, 0);
        wb(1, A_IMASK, 32'h30, q);
        repeat (3) @(posedge clk_sys);
        chk("irq_clr", {31'h0, irq}, 0);
        wb(0, A_STATUS, 0, q); chk("flags", {24'h0, q[7:0]}, 0);
        wb(0, A_DATA0 + 8'h08, 0, q);
        chk("data2_fall", 32'(q >= f(38, 4, fac[2], 0)
            && q <= f(42, 4, fac[2], 0)), 1);
        // Edges every 3 cycles: only the high range on ch0 keeps all
        wb(1, A_CFG0, 32'h21, q);
        wb(1, A_DIV0, 32'h1, q);
        wb(1, A_CFG0 + 8'h04, 32'h21, q);
        hi_cyc <= {NCH{8'h01}};
        lo_cyc <= {NCH{8'h02}};
        repeat (1500) @(posedge clk_sys);
        wb(0, A_DATA0, 0, q);
        chk("data0_fast", 32'(q >= f(131, 4, 1, 0)
            && q <= f(135, 4, 1, 0)), 1);
        wb(0, A_DATA0 + 8'h04, 0, q);
        chk("data1_slow", 32'(q >= f(64, 4, 1, 0)
            && q <= f(69, 4, 1, 0)), 1);
        summarize();
    end
endmodule
`default_nettype wire
